// file: design/half_bridge_bbm.sv
/*
 One half bridge with break-before-make: both gates stay off for
 dead time + 1 cycles before either turns on.
 Assumes the demand comes from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module half_bridge_bbm
    import msp_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       demand_in,
    input  wire logic [3:0] bbm_dly_in,
    output logic            gate_hi_out,
    output logic            gate_lo_out
);
    logic [4:0] dead_ff;
    logic       last_ff;

    // ----------------------------------------------------------------
    // Dead time sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            dead_ff     <= 5'h00;
            last_ff     <= 1'b0;
            gate_hi_out <= 1'b0;
            gate_lo_out <= 1'b0;
        end else if (demand_in != last_ff) begin
            last_ff     <= demand_in;
            gate_hi_out <= 1'b0;
            gate_lo_out <= 1'b0;
            dead_ff     <= {1'b0, bbm_dly_in} + 5'h01;
        end else if (dead_ff > 5'h01) begin
            dead_ff <= dead_ff - 5'h01;
        end else begin
            dead_ff     <= 5'h00;
            gate_hi_out <= last_ff;
            gate_lo_out <= ~last_ff;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [4:0] off_cnt_ff;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            off_cnt_ff <= 5'h00;
        end else if (gate_hi_out || gate_lo_out) begin
            off_cnt_ff <= 5'h00;
        end else if (off_cnt_ff != 5'h1F) begin
            off_cnt_ff <= off_cnt_ff + 5'h01;
        end
    end

    a_bbm_gap: assert property (@(posedge clk_in) disable iff (rst_in)
        ($rose(gate_hi_out) || $rose(gate_lo_out)) && $stable(bbm_dly_in)
            |-> $past(off_cnt_ff) >= {1'b0, bbm_dly_in})
        else $error("dead time shorter than setting");
    a_no_shoot: assert property (@(posedge clk_in) disable iff (rst_in)
        !(gate_hi_out && gate_lo_out))
        else $error("both gates on");
endmodule : half_bridge_bbm
`default_nettype wire

// file: design/microstep_angle_position_pwm.sv
/*
 Step-driven position counter, micro-step angle accumulator, PWM duty
 logic and SPI register slave of a micro-step sequencer.
 Assumes step and SPI pins are asynchronous; the sine magnitude comes
 from an outside table on the same clock, indexed by table_index_out.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Each step adds increment to position, except a step in the same cycle as a position write
// - Each step adds integer plus fraction width, except a step in the same cycle as an angle load
// - Top ten angle bits index sine table
// - Period spans four or six full steps
// - Fraction carried, only integer indexes table
// - PWM period 1024 times divider plus one
// - Dead time lasts setting plus one cycles
// - Signed amplitude sets magnitude and polarity
// - Sub-modulation dithers amplitude for finer resolution
// - Offset added to sine duty values
// - Slow decay shrinks duty after polarity change
// - Four-byte datagrams, bit seven marks write
// - Identity read returns type and version
module microstep_angle_position_pwm
    import msp_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       step_in,
    input  wire logic       spi_sck_in,
    input  wire logic       spi_cs_n_in,
    input  wire logic       spi_mosi_in,
    input  wire logic [8:0] sine_value_in,
    output logic            spi_miso_out,
    output logic [9:0]      table_index_out,
    output logic [2:0]      full_step_out,
    output logic            bridge_a_hi_out,
    output logic            bridge_a_lo_out,
    output logic            bridge_b_hi_out,
    output logic            bridge_b_lo_out
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] step_s_ff, sck_s_ff, cs_n_s_ff;
    logic [1:0] mosi_s_ff;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            step_s_ff <= 3'h0;
            sck_s_ff  <= 3'h0;
            cs_n_s_ff <= 3'h7;
            mosi_s_ff <= 2'h0;
        end else begin
            step_s_ff <= {step_s_ff[1:0], step_in};
            sck_s_ff  <= {sck_s_ff[1:0], spi_sck_in};
            cs_n_s_ff <= {cs_n_s_ff[1:0], spi_cs_n_in};
            mosi_s_ff <= {mosi_s_ff[0], spi_mosi_in};
        end
    end
    logic step_evt, sck_rise, sck_fall, cs_start, cs_end, sel;
    assign step_evt = step_s_ff[1] & ~step_s_ff[2];
    assign sck_rise = sck_s_ff[1] & ~sck_s_ff[2];
    assign sck_fall = ~sck_s_ff[1] & sck_s_ff[2];
    assign cs_start = ~cs_n_s_ff[1] & cs_n_s_ff[2];
    assign cs_end   = cs_n_s_ff[1] & ~cs_n_s_ff[2];
    assign sel      = ~cs_n_s_ff[1];

    // ----------------------------------------------------------------
    // SPI datagram engine
    // ----------------------------------------------------------------
    logic [31:0] rx_ff;
    logic [5:0]  bit_cnt_ff;
    logic [23:0] tx_ff;
    logic [23:0] rd_data;
    logic [6:0]  rd_addr;
    logic        wr_evt;
    logic [23:0] pos_inc_ff, phi_frac_ff, phi_int_ff, amp_reg_ff, frq_reg_ff;
    logic        ph3_ff;
    logic [31:0] pos_ff;

    assign rd_addr = rx_ff[6:0];
    assign wr_evt  = cs_end && bit_cnt_ff == 6'(SPI_BITS) && rx_ff[31];

    always_comb begin
        case (rd_addr)
            ADR_POS_LO:   rd_data = pos_ff[23:0];
            ADR_POS_HI:   rd_data = {16'h0000, pos_ff[31:24]};
            ADR_POS_INC:  rd_data = pos_inc_ff;
            ADR_PHI_FRAC: rd_data = phi_frac_ff;
            ADR_PHI_INT:  rd_data = phi_int_ff;
            ADR_PWM_AMP:  rd_data = amp_reg_ff;
            ADR_PWM_FRQ:  rd_data = frq_reg_ff;
            ADR_CTRL:     rd_data = {23'h000000, ph3_ff};
            ADR_CHIP_ID:  rd_data = {CHIP_TYPE, CHIP_VERSION, 8'h00};
            default:      rd_data = 24'h000000;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_ff      <= 32'h00000000;
            bit_cnt_ff <= 6'h00;
        end else if (cs_start) begin
            bit_cnt_ff <= 6'h00;
        end else if (sel && sck_rise && bit_cnt_ff != 6'(SPI_BITS)) begin
            rx_ff      <= {rx_ff[30:0], mosi_s_ff[1]};
            bit_cnt_ff <= bit_cnt_ff + 6'h01;
        end
    end

    // Reply byte 0 is zero; data follows only for a read address
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_ff        <= 24'h000000;
            spi_miso_out <= 1'b0;
        end else if (cs_start) begin
            tx_ff        <= 24'h000000;
            spi_miso_out <= 1'b0;
        end else if (sel && bit_cnt_ff == 6'h08 && sck_fall) begin
            spi_miso_out <= tx_ff[23];
            tx_ff        <= {tx_ff[22:0], 1'b0};
        end else if (sel && bit_cnt_ff > 6'h08 && sck_fall) begin
            spi_miso_out <= tx_ff[23];
            tx_ff        <= {tx_ff[22:0], 1'b0};
        end else if (bit_cnt_ff == 6'h08 && sck_s_ff[2] && !sck_s_ff[1]) begin
            tx_ff <= tx_ff;
        end else if (bit_cnt_ff == 6'h08 && $bits(rx_ff) == 32 && !rx_ff[7]
                     && sck_s_ff[2] == sck_s_ff[1] && sck_s_ff[1]) begin
            tx_ff <= rd_data;
        end
    end

    // ----------------------------------------------------------------
    // Parameter registers
    // ----------------------------------------------------------------
    logic load_phi;
    assign load_phi = wr_evt && rx_ff[30:24] == ADR_CTRL && rx_ff[LOAD_BIT];
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pos_inc_ff  <= REG_RESET;
            phi_frac_ff <= REG_RESET;
            phi_int_ff  <= REG_RESET;
            amp_reg_ff  <= REG_RESET;
            frq_reg_ff  <= REG_RESET;
            ph3_ff      <= 1'b0;
        end else if (wr_evt) begin
            case (rx_ff[30:24])
                ADR_POS_INC:  pos_inc_ff  <= rx_ff[23:0];
                ADR_PHI_FRAC: phi_frac_ff <= rx_ff[23:0];
                ADR_PHI_INT:  phi_int_ff  <= rx_ff[23:0];
                ADR_PWM_AMP:  amp_reg_ff  <= rx_ff[23:0];
                ADR_PWM_FRQ:  frq_reg_ff  <= rx_ff[23:0];
                ADR_CTRL:     ph3_ff      <= rx_ff[PH3_BIT];
                default:      ph3_ff      <= ph3_ff;
            endcase
        end
    end
    pwm_cfg_t cfg;
    assign cfg = '{amp: amp_reg_ff[AMP_LSB +: 9], sub_frac: amp_reg_ff[SUBF_LSB +: 4],
                   sub_en: amp_reg_ff[SUBM_BIT], offset: amp_reg_ff[OFS_LSB +: 7],
                   bbm_dly: frq_reg_ff[BBM_LSB +: 4], fdiv: frq_reg_ff[FDIV_LSB +: 4],
                   slow_decay_setting: frq_reg_ff[SLD_LSB +: 3]};

    // ----------------------------------------------------------------
    // Position and angle accumulators
    // ----------------------------------------------------------------
    logic [33:0] phi_ff;
    logic [33:0] phi_step;
    // Upper integer bits beyond ten only alias, so they are dropped
    assign phi_step = {phi_int_ff[9:0], phi_frac_ff};
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pos_ff <= 32'h00000000;
        end else if (wr_evt && rx_ff[30:24] == ADR_POS_LO) begin
            pos_ff <= {pos_ff[31:24], rx_ff[23:0]};
        end else if (wr_evt && rx_ff[30:24] == ADR_POS_HI) begin
            pos_ff <= {rx_ff[7:0], pos_ff[23:0]};
        end else if (step_evt) begin
            pos_ff <= pos_ff + {{8{pos_inc_ff[23]}}, pos_inc_ff};
        end
    end
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            phi_ff <= 34'h000000000;
        end else if (load_phi) begin
            phi_ff <= phi_step;
        end else if (step_evt) begin
            phi_ff <= phi_ff + phi_step;
        end
    end
    logic [12:0] idx_x6;
    assign idx_x6 = {3'h0, phi_ff[33:24]} * 13'h0006;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            table_index_out <= 10'h000;
            full_step_out   <= 3'h0;
        end else begin
            table_index_out <= phi_ff[33:24];
            full_step_out   <= ph3_ff ? idx_x6[12:10] : {1'b0, phi_ff[33:32]};
        end
    end

    // ----------------------------------------------------------------
    // PWM timebase
    // ----------------------------------------------------------------
    logic [3:0] div_ff;
    logic [9:0] pwm_cnt_ff;
    logic       pwm_ce, period_end;
    assign pwm_ce     = div_ff == cfg.fdiv;
    assign period_end = pwm_ce && pwm_cnt_ff == 10'(PWM_STEPS - 1);
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_ff     <= 4'h0;
            pwm_cnt_ff <= 10'h000;
        end else begin
            div_ff <= pwm_ce ? 4'h0 : div_ff + 4'h1;
            if (pwm_ce) begin
                pwm_cnt_ff <= pwm_cnt_ff + 10'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Duty computation, latched at period end to avoid glitches
    // ----------------------------------------------------------------
    logic [3:0]  sub_cnt_ff;
    logic [9:0]  duty_ff;
    logic        pol_ff, decay_ff;
    logic [8:0]  mag, eff;
    logic [17:0] prod;
    logic [10:0] sum;
    logic [9:0]  duty_full;
    assign mag  = cfg.amp[8] ? 9'(-cfg.amp) : cfg.amp;
    assign eff  = mag + {8'h00, cfg.sub_en && sub_cnt_ff < cfg.sub_frac};
    assign prod = sine_value_in * eff;
    assign sum  = {1'b0, prod[17:8]} + {4'h0, cfg.offset};
    assign duty_full = sum[10] ? 10'h3FF : sum[9:0];
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sub_cnt_ff <= 4'h0;
            duty_ff    <= 10'h000;
            pol_ff     <= 1'b0;
            decay_ff   <= 1'b0;
        end else if (period_end) begin
            sub_cnt_ff <= sub_cnt_ff + 4'h1;
            pol_ff     <= cfg.amp[8];
            decay_ff   <= cfg.amp[8] != pol_ff;
            duty_ff    <= (cfg.amp[8] != pol_ff) ? duty_full >> cfg.slow_decay_setting
                                                  : duty_full;
        end
    end
    logic pwm_on;
    assign pwm_on = pwm_cnt_ff < duty_ff;

    half_bridge_bbm u_bridge_a (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .demand_in   (pwm_on & ~pol_ff),
        .bbm_dly_in  (cfg.bbm_dly),
        .gate_hi_out (bridge_a_hi_out),
        .gate_lo_out (bridge_a_lo_out)
    );
    half_bridge_bbm u_bridge_b (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .demand_in   (pwm_on & pol_ff),
        .bbm_dly_in  (cfg.bbm_dly),
        .gate_hi_out (bridge_b_hi_out),
        .gate_lo_out (bridge_b_lo_out)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [15:0] gap_ff;
    logic        seen_ff;
    logic [3:0]  fdiv_q_ff;
    // A divider change inside a period makes that period odd, so skip it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gap_ff    <= 16'h0000;
            seen_ff   <= 1'b0;
            fdiv_q_ff <= 4'h0;
        end else begin
            fdiv_q_ff <= cfg.fdiv;
            if (period_end) begin
                gap_ff  <= 16'h0000;
                seen_ff <= cfg.fdiv == fdiv_q_ff;
            end else begin
                gap_ff <= gap_ff + 16'h0001;
                if (cfg.fdiv != fdiv_q_ff) begin
                    seen_ff <= 1'b0;
                end
            end
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_pos_step: assert property (
        step_evt && !wr_evt |=> pos_ff == $past(pos_ff) + {{8{$past(pos_inc_ff[23])}},
                                                           $past(pos_inc_ff)})
        else $error("position did not advance by increment");
    a_phi_step: assert property (
        step_evt && !load_phi |=> phi_ff == $past(phi_ff) + $past(phi_step))
        else $error("angle did not advance by step width");
    a_index_top: assert property (
        ##1 table_index_out == $past(phi_ff[33:24]))
        else $error("table index is not angle top bits");
    a_full_two: assert property (
        !ph3_ff && $stable(ph3_ff) ##1 1 |-> full_step_out == {1'b0, $past(phi_ff[33:32])})
        else $error("two-phase full step wrong");
    a_phi_load: assert property (
        load_phi |=> phi_ff == $past(phi_step))
        else $error("angle load failed");
    a_pwm_period: assert property (
        period_end && seen_ff && $stable(cfg.fdiv)
            |-> gap_ff == 16'(PWM_STEPS * ({12'h000, cfg.fdiv} + 1) - 1))
        else $error("PWM period wrong");
    a_decay_duty: assert property (
        period_end && cfg.amp[8] != pol_ff
            |=> decay_ff && duty_ff == $past(duty_full) >> $past(cfg.slow_decay_setting))
        else $error("slow decay duty wrong");
    a_id_read: assert property (
        $rose(bit_cnt_ff == 6'h08) && rx_ff[7:0] == {1'b0, ADR_CHIP_ID}
            ##[1:4] (tx_ff != 24'h000000) |-> tx_ff == {CHIP_TYPE, CHIP_VERSION, 8'h00})
        else $error("identity reply wrong");
    a_write_reg: assert property (
        wr_evt && rx_ff[30:24] == ADR_PHI_INT |=> phi_int_ff == $past(rx_ff[23:0]))
        else $error("register write lost");

    c_step: cover property (step_evt ##1 pos_ff != 32'h00000000);
    c_load: cover property (load_phi);
    c_pol:  cover property (period_end && cfg.amp[8] != pol_ff);
    c_read: cover property (sel && bit_cnt_ff == 6'h20);
endmodule : microstep_angle_position_pwm
`default_nettype wire

// file: design/msp_pkg.sv
/*
 Package: register map, field layout, timing and carrier types of the
 micro-step angle, position and PWM block.
 Assumes a single 200 MHz system clock and an SPI host on four pins.
*/
package msp_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [6:0] ADR_POS_LO   = 7'h00;
    localparam logic [6:0] ADR_POS_HI   = 7'h01;
    localparam logic [6:0] ADR_POS_INC  = 7'h02;
    localparam logic [6:0] ADR_PHI_FRAC = 7'h03;
    localparam logic [6:0] ADR_PHI_INT  = 7'h04;
    localparam logic [6:0] ADR_PWM_AMP  = 7'h06;
    localparam logic [6:0] ADR_PWM_FRQ  = 7'h07;
    localparam logic [6:0] ADR_CTRL     = 7'h08;
    localparam logic [6:0] ADR_CHIP_ID  = 7'h0F;
    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int AMP_LSB  = 0;    // Signed amplitude, 9 bits
    localparam int SUBF_LSB = 9;    // Sub-modulation fraction, 4 bits
    localparam int SUBM_BIT = 16;   // Sub-modulation enable
    localparam int OFS_LSB  = 17;   // Duty offset, 7 bits
    localparam int BBM_LSB  = 0;    // Dead time setting, 4 bits
    localparam int FDIV_LSB = 8;    // Frequency divider, 4 bits
    localparam int SLD_LSB  = 16;   // Slow decay shift, 3 bits
    localparam int PH3_BIT  = 0;    // Three-phase motor select
    localparam int LOAD_BIT = 2;    // Angle load command
    localparam logic [23:0] REG_RESET = 24'h000000;
    localparam logic [7:0]  CHIP_TYPE    = 8'hA5;  // Arbitrary value
    localparam logic [7:0]  CHIP_VERSION = 8'h01;  // Arbitrary value
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int PWM_STEPS     = 1024;
    localparam int BBM_MAX       = 15;
    localparam int SPI_BITS      = 32;
    // ----------------------------------------------------------------
    // Carrier
    // ----------------------------------------------------------------
    typedef struct packed {
        logic signed [8:0] amp;
        logic [3:0]        sub_frac;
        logic              sub_en;
        logic [6:0]        offset;
        logic [3:0]        bbm_dly;
        logic [3:0]        fdiv;
        logic [2:0]        slow_decay_setting;
    } pwm_cfg_t;
endpackage : msp_pkg

// file: testbench/spi_host_model.sv
/*
 Host model: issues 32-bit register datagrams to the block over SPI.
 Assumes it shares the block's system clock and the bench calls xfer.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    input  wire logic clk_in,
    input  wire logic miso_in,
    output var logic  sck_out,
    output var logic  cs_n_out,
    output var logic  mosi_out
);
    // ------------------------------------------------------------
    // Datagram
    // ------------------------------------------------------------
    initial begin
        sck_out  = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end

    // Half periods of 5 cycles, since SCK and CS pass a 3-stage sync and MOSI a 2-stage one
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h00000000;
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        repeat (5) @(posedge clk_in);
        for (int i = 31; i >= 0; i--) begin
            mosi_out <= tx[i];
            repeat (5) @(posedge clk_in);
            sck_out <= 1'b1;
            rx[i] = miso_in;
            repeat (5) @(posedge clk_in);
            sck_out <= 1'b0;
        end
        repeat (5) @(posedge clk_in);
        cs_n_out <= 1'b1;
        // Released line shows no stale bit
        mosi_out <= ~mosi_out;
        repeat (5) @(posedge clk_in);
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// file: testbench/tb_top.sv
/*
 Testbench: register, step, angle and PWM scenarios through SPI datagrams.
 Assumes the block sits alone with a host model and a constant sine value.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("BAD %0t got %0h want %0h", $time, got, exp); \
        end \
    end
module tb_top
    import msp_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       clk_in;
    logic       rst_in;
    logic       step_in;
    logic       sck;
    logic       cs_n;
    logic       mosi;
    logic       miso;
    logic [8:0] sine_value;
    logic [9:0] index;
    logic [2:0] full_step;
    logic       a_hi;
    logic       a_lo;
    logic       b_hi;
    logic       b_lo;
    int         checks;
    int         failures;
    logic [6:0] regs [8] = '{ADR_POS_LO, ADR_POS_HI, ADR_POS_INC, ADR_PHI_FRAC,
                              ADR_PHI_INT, ADR_PWM_AMP, ADR_PWM_FRQ, ADR_CTRL};

    always #2.5 clk_in = ~clk_in;

    microstep_angle_position_pwm dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .step_in(step_in),
        .spi_sck_in(sck), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
        .sine_value_in(sine_value), .spi_miso_out(miso),
        .table_index_out(index), .full_step_out(full_step),
        .bridge_a_hi_out(a_hi), .bridge_a_lo_out(a_lo),
        .bridge_b_hi_out(b_hi), .bridge_b_lo_out(b_lo)
    );

    spi_host_model host_u (
        .clk_in(clk_in), .miso_in(miso), .sck_out(sck),
        .cs_n_out(cs_n), .mosi_out(mosi)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [6:0] a, input logic [23:0] d);
        logic [31:0] rx;
        host_u.xfer({1'b1, a, d}, rx);
    endtask : wr

    task automatic rd_chk(input logic [6:0] a, input logic [23:0] exp);
        logic [31:0] rx;
        host_u.xfer({1'b0, a, 24'h000000}, rx);
        `CHK(rx, {8'h00, exp})
    endtask : rd_chk

    task automatic steps(input int n);
        repeat (n) begin
            @(posedge clk_in);
            step_in <= 1'b1;
            repeat (3) @(posedge clk_in);
            step_in <= 1'b0;
            repeat (3) @(posedge clk_in);
        end
        repeat (4) @(posedge clk_in);
        @(negedge clk_in);
    endtask : steps

    task automatic load_angle(input logic [23:0] ctrl, input logic [23:0] ang);
        wr(ADR_PHI_FRAC, 24'h000000);
        wr(ADR_PHI_INT, ang);
        wr(ADR_CTRL, ctrl | 24'h000004);
        wr(ADR_PHI_INT, 24'h000004);
        wr(ADR_PHI_FRAC, 24'h400000);
        @(negedge clk_in);
    endtask : load_angle

    // Period from one high-side rise to the next, dead gap before it
    task automatic pwm_check(input int per, input int dead);
        int n;
        int d;
        n = 0;
        d = 0;
        while (a_hi !== 1'b0 && n < 5000) begin @(negedge clk_in); n++; end
        while (a_hi !== 1'b1 && n < 9000) begin @(negedge clk_in); n++; end
        n = 0;
        while (a_hi === 1'b1 && n < 5000) begin @(negedge clk_in); n++; end
        while (a_hi !== 1'b1 && n < 5000) begin
            d = (a_lo === 1'b1) ? 0 : d + 1;
            @(negedge clk_in);
            n++;
        end
        `CHK(n, per)
        `CHK(d, dead)
    endtask : pwm_check

    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        #250000;
        failures++;
        complete_run();
    end

    initial begin
        clk_in = 1'b0;
        rst_in = 1'b1;
        step_in = 1'b0;
        sine_value = 9'h100;
        checks = 0;
        failures = 0;
        repeat (6) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        foreach (regs[i]) rd_chk(regs[i], REG_RESET);
        `CHK(index, 10'h000)
        rd_chk(ADR_CHIP_ID, {CHIP_TYPE, CHIP_VERSION, 8'h00});
        rd_chk(7'h05, 24'h000000);
        wr(ADR_PWM_AMP, 24'h000040);
        rd_chk(ADR_PWM_AMP, 24'h000040);
        // Negative increment exercises sign extension and wrap
        wr(ADR_POS_LO, 24'h000001);
        wr(ADR_POS_INC, 24'hFFFFFE);
        steps(3);
        rd_chk(ADR_POS_LO, 24'hFFFFFB);
        rd_chk(ADR_POS_HI, 24'h0000FF);
        wr(ADR_PHI_INT, 24'h000004);
        wr(ADR_PHI_FRAC, 24'h400000);
        steps(4);
        `CHK(index, 10'd17)
        load_angle(24'h000000, 24'h0003E8);
        `CHK(index, 10'd1000)
        `CHK(full_step, 3'd3)
        steps(8);
        `CHK(index, 10'd10)
        `CHK(full_step, 3'd0)
        load_angle(24'h000001, 24'h0002BC);
        `CHK(full_step, 3'd4)
        rd_chk(ADR_CTRL, 24'h000001);
        load_angle(24'h000000, 24'h000064);
        `CHK(index, 10'd100)
        `CHK(b_hi, 1'b0)
        wr(ADR_PWM_FRQ, 24'h00000F);
        pwm_check(1024, 16);
        wr(ADR_PWM_FRQ, 24'h000100);
        pwm_check(2048, 1);
        // Negative amplitude moves the drive to the other bridge
        wr(ADR_PWM_FRQ, 24'h010000);
        wr(ADR_PWM_AMP, 24'h0001C0);
        repeat (3000) @(posedge clk_in);
        @(negedge clk_in);
        `CHK(a_hi, 1'b0)
        `CHK(a_lo, 1'b1)
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
